// ===== hw/omc_top.sv
// Output macrocell configuration and data path for eight cells
`timescale 1ns/1ps
`default_nettype none
module omc_top
	import omc_pkg::*;
#(
	parameter int unsigned CELLS = OMC_CELLS,
	parameter int unsigned TERMS = OMC_TERMS
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Configuration bits
	input wire logic synchronous_select_bit_i,
	input wire logic global_architecture_bit_i,
	input wire logic [CELLS-1:0] polarity_bit_i,
	input wire logic [CELLS-1:0] cell_architecture_bit_i,
	// Product terms, cell c at bits c*TERMS up
	input wire logic [CELLS*TERMS-1:0] product_terms_i,
	// Pins
	input wire logic clk_pin_i,
	input wire logic oe_pin_n_i,
	input wire logic [CELLS-1:0] cell_pin_i,
	output logic [CELLS-1:0] cell_pin_o,
	output logic [CELLS-1:0] cell_pin_oe_n_o,
	// Into the array
	output logic [CELLS-1:0] feedback_o,
	output logic [OMC_DED_PINS-1:0] dedicated_in_o,
	output logic [1:0] mode_o
);
	// Whole block state, filled by one comb process
	typedef struct packed {
		// Pin synchronisers
		logic clk_s1;
		logic clk_s2;
		logic clk_prev;
		logic oe_n_s1;
		logic oe_n_s2;
		logic [CELLS-1:0] pin_s1;
		logic [CELLS-1:0] pin_s2;
		// Cell registers and output stages
		logic [CELLS-1:0] cell_q;
		logic [CELLS-1:0] pin_out;
		logic [CELLS-1:0] pin_oe_n;
		// Array-side copies
		logic [CELLS-1:0] fb;
		logic [OMC_DED_PINS-1:0] ded;
		logic [1:0] mode;
	} omc_state_t;

	omc_state_t st_ff;
	omc_state_t nxt_st;
	logic rst_s1_ff;
	logic rst_n_ff;
	omc_mode_t mode;
	logic [CELLS-1:0] sum;
	logic [CELLS-1:0] oe_term;
	logic [CELLS-1:0] term_is_oe;
	logic [CELLS-1:0] is_reg;

	// Unused code maps to simple so a blank part drives no registers
	function automatic omc_mode_t decode_mode(input logic sync_sel, input logic glob_arch);
		unique case ({sync_sel, glob_arch})
			OMC_CODE_COMPLEX: decode_mode = OMC_MODE_COMPLEX;
			OMC_CODE_REGISTERED: decode_mode = OMC_MODE_REGISTERED;
			default: decode_mode = OMC_MODE_SIMPLE;
		endcase
	endfunction

	// Polarity is the last stage in every mode
	function automatic logic apply_pol(input logic val, input logic pol);
		apply_pol = val ^ (pol == OMC_POL_INVERT);
	endfunction

	// Enable term high drives the pin, low leaves it to the board
	function automatic logic term_oe_n(input logic term);
		term_oe_n = term ? OMC_OE_N_DRIVE : OMC_OE_N_FLOAT;
	endfunction

	// Reset asserts at once and lifts two edges after the pin
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	assign mode = decode_mode(synchronous_select_bit_i, global_architecture_bit_i);

	// Per-cell term summing; registers keep all eight terms
	genvar c;
	generate
		for (c = 0; c < CELLS; c++) begin : g_cell
			assign is_reg[c] = (mode == OMC_MODE_REGISTERED) &&
				(cell_architecture_bit_i[c] != OMC_ARCH_IO);
			assign term_is_oe[c] = (mode != OMC_MODE_SIMPLE) && !is_reg[c];
			omc_term_sum #(
				.TERMS(TERMS)
			) u_sum (
				.terms_i(product_terms_i[c*TERMS +: TERMS]),
				.term_is_oe_i(term_is_oe[c]),
				.sum_o(sum[c]),
				.oe_term_o(oe_term[c])
			);
		end
	endgenerate

	always_comb begin
		logic clk_rise;
		logic forced_out;
		logic inner;
		clk_rise = 1'b0;
		forced_out = 1'b0;
		inner = 1'b0;
		nxt_st = st_ff;
		// Two-flop synchronisers for every pin input
		nxt_st.clk_s1 = clk_pin_i;
		nxt_st.clk_s2 = st_ff.clk_s1;
		nxt_st.clk_prev = st_ff.clk_s2;
		nxt_st.oe_n_s1 = oe_pin_n_i;
		nxt_st.oe_n_s2 = st_ff.oe_n_s1;
		nxt_st.pin_s1 = cell_pin_i;
		nxt_st.pin_s2 = st_ff.pin_s1;
		nxt_st.mode = mode;
		// Edge taken from the second stage, never the first
		clk_rise = st_ff.clk_s2 && !st_ff.clk_prev;
		for (int i = 0; i < CELLS; i++) begin
			inner = (i == OMC_INNER_LO) || (i == OMC_INNER_HI);
			if (is_reg[i] && clk_rise) begin
				nxt_st.cell_q[i] = sum[i];
			end
			// Mode sets the enable source and feedback route
			unique case (mode)
				OMC_MODE_REGISTERED: begin
					if (is_reg[i]) begin
						nxt_st.pin_out[i] = apply_pol(st_ff.cell_q[i], polarity_bit_i[i]);
						nxt_st.pin_oe_n[i] = st_ff.oe_n_s2;
						nxt_st.fb[i] = st_ff.cell_q[i];
					end else begin
						nxt_st.pin_out[i] = apply_pol(sum[i], polarity_bit_i[i]);
						// A low enable term leaves the pin a pure input
						nxt_st.pin_oe_n[i] = term_oe_n(oe_term[i]);
						nxt_st.fb[i] = st_ff.pin_s2[i];
					end
				end
				OMC_MODE_COMPLEX: begin
					nxt_st.pin_out[i] = apply_pol(sum[i], polarity_bit_i[i]);
					nxt_st.pin_oe_n[i] = term_oe_n(oe_term[i]);
					if (i == OMC_OUTER_HI) begin
						nxt_st.fb[i] = st_ff.clk_s2;
					end else if (i == OMC_OUTER_LO) begin
						nxt_st.fb[i] = st_ff.oe_n_s2;
					end else begin
						nxt_st.fb[i] = st_ff.pin_s2[i];
					end
				end
				default: begin
					forced_out = inner || (cell_architecture_bit_i[i] != OMC_ARCH_IO);
					nxt_st.pin_out[i] = apply_pol(sum[i], polarity_bit_i[i]);
					nxt_st.pin_oe_n[i] = forced_out ? OMC_OE_N_DRIVE : OMC_OE_N_FLOAT;
					// Inner pins feed nothing; neighbours shift inward
					if (i == OMC_OUTER_LO) begin
						nxt_st.fb[i] = st_ff.oe_n_s2;
					end else if (i == OMC_OUTER_HI) begin
						nxt_st.fb[i] = st_ff.clk_s2;
					end else if (i <= OMC_INNER_LO) begin
						nxt_st.fb[i] = st_ff.pin_s2[i-1];
					end else begin
						nxt_st.fb[i] = st_ff.pin_s2[i+1];
					end
				end
			endcase
		end
		// Dedicated pins reach the array only outside registered mode
		if (mode == OMC_MODE_REGISTERED) begin
			nxt_st.ded = '0;
		end else begin
			nxt_st.ded[OMC_DED_CLK] = st_ff.clk_s2;
			nxt_st.ded[OMC_DED_OE] = st_ff.oe_n_s2;
		end
	end

	// Pins released in reset so the board never sees a stray drive
	always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			st_ff <= '0;
			st_ff.pin_oe_n <= '1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// All outputs come straight from the state register
	assign cell_pin_o = st_ff.pin_out;
	assign cell_pin_oe_n_o = st_ff.pin_oe_n;
	assign feedback_o = st_ff.fb;
	assign dedicated_in_o = st_ff.ded;
	assign mode_o = st_ff.mode;
endmodule
`default_nettype wire

// ===== inc/omc_pkg.sv
// Shared constants and types for the output macrocell configuration block
package omc_pkg;

	localparam int unsigned OMC_CELLS = 8;
	localparam int unsigned OMC_TERMS = 8;
	localparam int unsigned OMC_DED_PINS = 2;

	// Outer cells lend their feedback to the dedicated pins in simple and complex mode
	localparam int unsigned OMC_OUTER_LO = 0;
	localparam int unsigned OMC_OUTER_HI = 7;
	// Inner cells are forced outputs in simple mode
	localparam int unsigned OMC_INNER_LO = 3;
	localparam int unsigned OMC_INNER_HI = 4;

	// Index of the product term that becomes the tri-state enable
	localparam int unsigned OMC_OE_TERM = 0;

	// Dedicated pin positions on the dedicated input vector
	localparam int unsigned OMC_DED_CLK = 0;
	localparam int unsigned OMC_DED_OE = 1;

	typedef enum logic [1:0] {
		OMC_MODE_SIMPLE = 2'h0,
		OMC_MODE_COMPLEX = 2'h1,
		OMC_MODE_REGISTERED = 2'h2
	} omc_mode_t;

	// Polarity bit value that inverts the cell output
	localparam logic OMC_POL_INVERT = 1'h1;
	// Cell architecture bit value that selects the input/output function
	localparam logic OMC_ARCH_IO = 1'h1;
	// Synchronous-select and global architecture codes
	localparam logic [1:0] OMC_CODE_SIMPLE = 2'h2;
	localparam logic [1:0] OMC_CODE_COMPLEX = 2'h3;
	localparam logic [1:0] OMC_CODE_REGISTERED = 2'h1;

	localparam logic OMC_OE_N_DRIVE = 1'h0;
	localparam logic OMC_OE_N_FLOAT = 1'h1;

endpackage

// ===== hw/omc_term_sum.sv
// Product-term summing for one output macrocell
`timescale 1ns/1ps
`default_nettype none
module omc_term_sum
	import omc_pkg::*;
#(
	parameter int unsigned TERMS = OMC_TERMS
) (
	// Product terms from the array
	input wire logic [TERMS-1:0] terms_i,
	// One term steers the tri-state enable instead of the logic
	input wire logic term_is_oe_i,
	// Results
	output logic sum_o,
	output logic oe_term_o
);
	logic [TERMS-1:0] mask;

	always_comb begin
		mask = '1;
		if (term_is_oe_i) begin
			mask[OMC_OE_TERM] = 1'b0;
		end
		sum_o = |(terms_i & mask);
		oe_term_o = terms_i[OMC_OE_TERM];
	end
endmodule
`default_nettype wire

// ===== test/omc_board.sv
// Board model for the eight cell pins
`timescale 1ns/1ps
`default_nettype none
module omc_board (
	// Device side
	input wire logic [7:0] cell_pin_o,
	input wire logic [7:0] cell_pin_oe_n_o,
	// Board level on released pins
	input wire logic [7:0] bd_val_i,
	// Levels seen by the device
	output logic [7:0] cell_pin_i
);
	assign cell_pin_i = (cell_pin_oe_n_o & bd_val_i) | (~cell_pin_oe_n_o & cell_pin_o);
endmodule
`default_nettype wire

// ===== test/omc_chk_assertions.sv
// Port properties of the macrocell block
`timescale 1ns/1ps
`default_nettype none
module omc_chk
	import omc_pkg::*;
(
	// Clock, reset, inputs
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic synchronous_select_bit_i,
	input wire logic global_architecture_bit_i,
	input wire logic [7:0] polarity_bit_i,
	input wire logic [7:0] cell_architecture_bit_i,
	input wire logic [63:0] product_terms_i,
	input wire logic clk_pin_i,
	input wire logic oe_pin_n_i,
	// Outputs
	input wire logic [7:0] cell_pin_o,
	input wire logic [7:0] cell_pin_oe_n_o,
	input wire logic [7:0] feedback_o,
	input wire logic [1:0] dedicated_in_o,
	input wire logic [1:0] mode_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Synchronisers need a few edges after reset
	logic [2:0] up_ff;
	wire ok = up_ff == 3'h7;
	wire sm = ok && mode_o == OMC_MODE_SIMPLE;
	wire cx = ok && mode_o == OMC_MODE_COMPLEX;
	wire rg = ok && mode_o == OMC_MODE_REGISTERED;
	wire [1:0] cd = {synchronous_select_bit_i, global_architecture_bit_i};
	wire [1:0] em = cd == OMC_CODE_COMPLEX ? 2'h1 : cd == OMC_CODE_REGISTERED ? 2'h2 : 2'h0;
	wire s0 = (|product_terms_i[7:0]) ^ polarity_bit_i[0];
	wire [1:0] c1 = {!product_terms_i[8], (|product_terms_i[15:9]) ^ polarity_bit_i[1]};
	wire [1:0] dp = {clk_pin_i, oe_pin_n_i};
	wire a0 = cell_architecture_bit_i[0];
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			up_ff <= 3'h0;
		else if (!ok)
			up_ff <= up_ff + 3'h1;
	end
	sequence s_rise;
		rg && !a0 && $rose(clk_pin_i);
	endsequence
	sequence s_steady;
		(rg && $stable(s0))[*6];
	endsequence
	a_mode_decode:
		assert property (ok |-> mode_o == $past(em)) else $error("mode decode");
	a_reg_no_ded:
		assert property (rg |-> dedicated_in_o == 2'h0) else $error("dedicated leak");
	a_inner_drive:
		assert property (sm |-> cell_pin_oe_n_o[4:3] == 2'h0) else $error("inner float");
	a_simple_out:
		assert property (sm |-> cell_pin_o[0] == $past(s0)) else $error("simple out");
	a_cplx_term:
		assert property (cx |-> {cell_pin_oe_n_o[1], cell_pin_o[1]} == $past(c1))
			else $error("complex cell");
	a_cplx_borrow:
		assert property (cx |-> {feedback_o[7], feedback_o[0]} == $past(dp, 3))
			else $error("complex feedback");
	a_reg_common_oe:
		assert property (rg && !$past(a0) |-> cell_pin_oe_n_o[0] == $past(oe_pin_n_i, 3))
			else $error("common enable");
	a_reg_capture:
		assert property (s_rise ##1 s_steady |-> cell_pin_o[0] == s0) else $error("capture");
endmodule
`default_nettype wire

// ===== test/tb.sv
// Directed bench for the macrocell block
`timescale 1ns/1ps
`default_nettype none
module tb
	import omc_pkg::*;
;
	logic ref_clk_i = 1'h0;
	logic arst_n_i = 1'h0;
	logic synchronous_select_bit_i = 1'h0;
	logic global_architecture_bit_i = 1'h0;
	logic [7:0] polarity_bit_i = 8'h00;
	logic [7:0] cell_architecture_bit_i = 8'h00;
	logic [63:0] product_terms_i = 64'h0;
	logic clk_pin_i = 1'h0;
	logic oe_pin_n_i = 1'h1;
	wire logic [7:0] cell_pin_i, cell_pin_o, cell_pin_oe_n_o, feedback_o;
	wire logic [1:0] dedicated_in_o, mode_o;
	// Fields: mode, dedicated, out, enable, feedback
	wire logic [31:0] obs = {4'h0, mode_o, dedicated_in_o, cell_pin_o, cell_pin_oe_n_o, feedback_o};
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	omc_top u_omc_top (.*);
	omc_board u_omc_board (.cell_pin_o, .cell_pin_oe_n_o, .bd_val_i(8'hff), .cell_pin_i);
	always #10 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 1000) begin
			fails++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] msk, input logic [31:0] exp);
		num_checks++;
		if ((obs & msk) !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, obs & msk);
		end
	endtask
	task automatic cfg(input logic [1:0] cd, input logic [7:0] pol, input logic [7:0] arch,
		input logic [63:0] pt);
		@(negedge ref_clk_i);
		{synchronous_select_bit_i, global_architecture_bit_i} = cd;
		polarity_bit_i = pol;
		cell_architecture_bit_i = arch;
		product_terms_i = pt;
		repeat (5) @(negedge ref_clk_i);
	endtask
	task automatic pulse();
		clk_pin_i = 1'h1;
		repeat (3) @(negedge ref_clk_i);
		clk_pin_i = 1'h0;
		repeat (5) @(negedge ref_clk_i);
	endtask
	initial begin
		repeat (8) @(negedge ref_clk_i);
		arst_n_i = 1'h1;
		for (int k = 0; k < 4; k++) begin
			cfg(2'(k), 8'h00, 8'h00, 64'h0);
			chk("mode", 32'h0c000000, {4'h0, k == 3 ? 2'h1 : k == 1 ? 2'h2 : 2'h0, 26'h0});
		end
		cfg(2'h2, 8'h0f, 8'h19, 64'h008000ff00ff00ff);
		chk("simple", 32'h0ffeffff, 32'h025a0127);
		cfg(2'h3, 8'h06, 8'h00, 64'h02018100);
		chk("complex", 32'h0f06ffff, 32'h0604f97d);
		cfg(2'h1, 8'h02, 8'h02, 64'h0180);
		chk("reg idle", 32'h0f01ffff, 32'h0800fd02);
		oe_pin_n_i = 1'h0;
		pulse();
		chk("reg load", 32'h00ffffff, 32'h00030003);
		cfg(2'h1, 8'h02, 8'h02, 64'h0);
		chk("reg keep", 32'h00010000, 32'h00010000);
		pulse();
		chk("reg next", 32'h00010000, 32'h00000000);
		arst_n_i = 1'h0;
		repeat (2) @(negedge ref_clk_i);
		chk("reset", 32'h0fffffff, 32'h0000ff00);
		arst_n_i = 1'h1;
		cfg(2'h3, 8'h00, 8'h00, 64'h0);
		chk("mode again", 32'h0c000000, 32'h04000000);
		close_out();
	end
endmodule
bind omc_top omc_chk u_omc_chk (.*);
`default_nettype wire
